// ### spi_loop_cfg.svh
`ifndef SPI_LOOP_CFG_SVH
`define SPI_LOOP_CFG_SVH
// register byte addresses
`define OFS_CFG   12'h000
`define OFS_TX    12'h004
`define OFS_EXE   12'h008
`define OFS_RX    12'h00C
`define OFS_DIAG  12'h010
`define OFS_STAT  12'h014
// configuration register fields
// count field holds 1 to 7 as written; zero asks for a full byte
`define CFG_NBITS_LSB  0
`define CFG_CPHA_BIT   5
`define CFG_CPOL_BIT   6
`define CFG_EN_BIT     3
`define CFG_SS_BIT     4
`define CFG_RESET      8'h10
// diagnostic and execute fields
`define DIAG_LOOP_BIT  0
`define EXE_GO_BIT     0
// serial clock half period
`define HALF_PERIOD_NS 20
`define CLK_PERIOD_NS  4
`define HALF_CYCLES    ((`HALF_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### spi_loop_pkg.sv
package spi_loop_pkg;
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic ss;
	} spi_pins_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_LEAD  = 3'b010,
		ST_TRAIL = 3'b100
	} xfer_state_t;
endpackage

// ### serial_master_loopback.sv
// Behaviour
// - a diagnostic control bit switches the loopback self-test on and off.
// - in loopback the transmit bits feed the serial input internally.
// - config, transmit and execute writes work as normal; execute starts transfer.
// - in loopback the mosi and select pins stay static; sclk follows the current CPOL bit.
// - after loopback transfer receive register equals the transmit bits.
// - slave select frozen at its value when loopback is entered.
// - execute starts transfer of 1 to 8 bits sampled at trigger.
// - short transfers send and fill starting from bit 0.
// - each transfer shifts out and captures in at the same time.
`timescale 1ns/100ps
`include "spi_loop_cfg.svh"
module serial_master_loopback (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hsel,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              miso,
	output spi_loop_pkg::spi_pins_t spi_out
);
	import spi_loop_pkg::*;

	logic [7:0]  cfg_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic        loop_q;
	logic        ss_lat_q;
	logic        wr_q;
	logic [11:0] addr_q;
	logic        go;
	logic        miso_s1_q;
	logic        miso_s2_q;
	xfer_state_t st_q;
	logic [2:0]  cnt_q;
	logic [2:0]  last_q;
	logic [7:0]  div_q;
	logic        sclk_q;
	logic        mosi_q;
	logic        busy;
	logic        half_done;
	logic        rx_bit;
	logic        cpol;
	logic        cpha;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign busy      = (st_q != ST_IDLE);
	assign cpha      = cfg_q[`CFG_CPHA_BIT];
	assign cpol      = cfg_q[`CFG_CPOL_BIT];
	assign half_done = (div_q == 8'(`HALF_CYCLES - 1));
	// internal return path replaces the pin in loopback
	assign rx_bit    = loop_q ? tx_q[cnt_q] : miso_s2_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_q   <= 1'b0;
			addr_q <= 12'h000;
		end
		else if (hready)
		begin
			wr_q   <= hsel && htrans[1] && hwrite;
			addr_q <= haddr[11:0];
		end
	end

	// execute pulse ignored while a transfer runs
	assign go = wr_q && addr_q == `OFS_EXE && hwdata[`EXE_GO_BIT] && !busy;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg_q  <= `CFG_RESET;
			tx_q   <= 8'h00;
			loop_q <= 1'b0;
		end
		else if (wr_q)
		begin
			if (addr_q == `OFS_CFG)
				cfg_q <= hwdata[7:0];
			if (addr_q == `OFS_TX)
				tx_q <= hwdata[7:0];
			if (addr_q == `OFS_DIAG)
				loop_q <= hwdata[`DIAG_LOOP_BIT];
		end
	end

	// select level captured on loopback entry only
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ss_lat_q <= 1'b1;
		else if (wr_q && addr_q == `OFS_DIAG && hwdata[`DIAG_LOOP_BIT] && !loop_q)
			ss_lat_q <= cfg_q[`CFG_SS_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			unique case (haddr[11:0])
				`OFS_CFG:  hrdata <= {24'h000000, cfg_q};
				`OFS_TX:   hrdata <= {24'h000000, tx_q};
				`OFS_RX:   hrdata <= {24'h000000, rx_q};
				`OFS_DIAG: hrdata <= {31'h00000000, loop_q};
				`OFS_STAT: hrdata <= {31'h00000000, busy};
				default:   hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end
		else
		begin
			miso_s1_q <= miso;
			miso_s2_q <= miso_s1_q;
		end
	end

	// two half periods per bit: with CPHA clear lead edge samples, trail edge shifts; with CPHA set lead shifts, trail samples
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q   <= ST_IDLE;
			cnt_q  <= 3'h0;
			last_q <= 3'h0;
			div_q  <= 8'h00;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			rx_q   <= 8'h00;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE:
				begin
					sclk_q <= cpol;
					div_q  <= 8'h00;
					if (go)
					begin
						// zero wraps to seven, so an empty count runs a full byte
						last_q <= cfg_q[`CFG_NBITS_LSB +: 3] - 3'h1;
						cnt_q  <= 3'h0;
						mosi_q <= tx_q[0];
						st_q   <= ST_LEAD;
					end
				end
				ST_LEAD:
				begin
					div_q <= half_done ? 8'h00 : div_q + 8'h01;
					if (half_done)
					begin
						sclk_q <= ~sclk_q;
						if (!cpha)
							rx_q[cnt_q] <= rx_bit;
						else
							mosi_q <= tx_q[cnt_q];
						st_q <= ST_TRAIL;
					end
				end
				ST_TRAIL:
				begin
					div_q <= half_done ? 8'h00 : div_q + 8'h01;
					if (half_done)
					begin
						sclk_q <= ~sclk_q;
						if (cpha)
							rx_q[cnt_q] <= rx_bit;
						if (cnt_q == last_q)
							st_q <= ST_IDLE;
						else
						begin
							cnt_q <= cnt_q + 3'h1;
							if (!cpha)
								mosi_q <= tx_q[cnt_q + 3'h1];
							st_q <= ST_LEAD;
						end
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// mosi and select frozen in loopback, sclk follows cpol; normal drive resumes when it clears
	always_comb
	begin
		if (loop_q)
		begin
			spi_out.sclk = cpol;
			spi_out.mosi = 1'b0;
			spi_out.ss   = ss_lat_q;
		end
		else
		begin
			spi_out.sclk = sclk_q;
			spi_out.mosi = mosi_q;
			spi_out.ss   = cfg_q[`CFG_SS_BIT];
		end
	end

	chk_loop_pins_static: assert property (@(posedge clk) disable iff (sys_rst)
		loop_q && $past(loop_q) && $stable(cfg_q) |-> $stable(spi_out))
		else $error("pins moved in loopback");
	chk_ss_frozen: assert property (@(posedge clk) disable iff (sys_rst)
		loop_q && $past(loop_q) |-> spi_out.ss == $past(spi_out.ss))
		else $error("select moved in loopback");
	chk_go_starts: assert property (@(posedge clk) disable iff (sys_rst)
		go |=> st_q == ST_LEAD)
		else $error("execute did not start");
	chk_bit_count: assert property (@(posedge clk) disable iff (sys_rst)
		go |=> last_q == $past(cfg_q[`CFG_NBITS_LSB +: 3]) - 3'h1)
		else $error("bit count not sampled");
	chk_start_bit0: assert property (@(posedge clk) disable iff (sys_rst)
		go |=> cnt_q == 3'h0 && mosi_q == $past(tx_q[0]))
		else $error("transfer not from bit 0");
	chk_loop_rx: assert property (@(posedge clk) disable iff (sys_rst)
		loop_q && st_q == ST_TRAIL && half_done && cnt_q == last_q && $stable(tx_q)
		|=> rx_q[$past(cnt_q)] == tx_q[$past(cnt_q)])
		else $error("loopback bit mismatch");
	chk_loop_source: assert property (@(posedge clk) disable iff (sys_rst)
		loop_q && half_done && ((st_q == ST_LEAD && !cpha) || (st_q == ST_TRAIL && cpha))
		|=> rx_q[$past(cnt_q)] == $past(tx_q[cnt_q]))
		else $error("loop path not internal");
	chk_release: assert property (@(posedge clk) disable iff (sys_rst)
		!loop_q |-> spi_out.ss == cfg_q[`CFG_SS_BIT] && spi_out.sclk == sclk_q)
		else $error("pins not released");
	chk_loop_bit: assert property (@(posedge clk) disable iff (sys_rst)
		wr_q && addr_q == `OFS_DIAG |=> loop_q == $past(hwdata[`DIAG_LOOP_BIT]))
		else $error("loopback bit not written");
endmodule // serial_master_loopback

// ### spi_slave_model.sv
`timescale 1ns/100ps
module spi_slave_model #(
	parameter logic [7:0] REPLY = 8'hC6
) (
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       ss,
	output logic            miso,
	output logic      [7:0] got,
	output int              edges
);
	logic [2:0] idx = 3'h0;
	initial got = 8'h00;
	initial edges = 0;
	// mode 0 slave: next bit after each falling edge, lsb first
	always @(negedge sclk or posedge ss)
		if (ss)
			idx <= 3'h0;
		else
			idx <= idx + 3'h1;
	always @(posedge sclk)
		if (!ss)
			got <= {mosi, got[7:1]};
	// motion on sclk or mosi is counted so a quiet bus can be proven
	always @(sclk or mosi)
		edges++;
	// deselected: show the inverse so a stale bit is never read as good
	assign miso = ss ? ~REPLY[idx] : REPLY[idx];
endmodule // spi_slave_model

// ### serial_master_loopback_tb_top.sv
`timescale 1ns/100ps
`include "spi_loop_cfg.svh"
module serial_master_loopback_tb_top;
	import spi_loop_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hsel = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        miso;
	logic [7:0]  got;
	int          edges;
	int          n_mismatch = 0;
	int          checks_done = 0;
	spi_pins_t   pins;
	always #2 clk = ~clk;
	serial_master_loopback serial_master_loopback_i (.clk(clk), .sys_rst(sys_rst),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .miso(miso), .spi_out(pins));
	spi_slave_model spi_slave_model_i (.sclk(pins.sclk), .mosi(pins.mosi), .ss(pins.ss),
		.miso(miso), .got(got), .edges(edges));
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr  <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsel   <= 1'b1;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		// taken at the closing edge, before the slave re-decodes the read port
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		xfer(1'b1, a, wd, d);
	endtask
	// poll busy; the serial side sets the pace, so no fixed wait is assumed
	task automatic run(input logic [7:0] tx, input logic [7:0] cfg, output logic [31:0] rx);
		logic [31:0] s;
		int i;
		wr(`OFS_CFG, {24'h0, cfg});
		wr(`OFS_TX, {24'h0, tx});
		wr(`OFS_EXE, 32'h1);
		for (i = 0; i < 100; i++)
		begin
			xfer(1'b0, `OFS_STAT, 32'h0, s);
			if (s[0] === 1'b0)
				break;
		end
		check("busy_done", s[0], 1'b0);
		xfer(1'b0, `OFS_RX, 32'h0, rx);
	endtask
	initial
	begin
		#200000;
		n_mismatch++;
		results();
	end
	logic [31:0] d;
	logic [7:0]  cfgs [2] = '{8'h08, 8'h1B};
	logic [7:0]  txs [2] = '{8'hA5, 8'h5B};
	logic [8:0]  mask;
	int          e0;
	initial
	begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		xfer(1'b0, `OFS_CFG, 32'h0, d);
		check("cfg_reset", d[7:0], `CFG_RESET);
		check("ss_reset", pins.ss, 1'b1);
		// normal 4-bit exchange with select low through the pins
		run(8'h0B, 8'h0C, d);
		check("slave_got", got[7:4], 4'hB);
		check("rx_normal", d[3:0], 4'h6);
		// mode bits settle before loopback; select is low at entry
		wr(`OFS_DIAG, 32'h1);
		// let the entry step on the data pin be counted before the snapshot
		@(posedge clk);
		e0 = edges;
		for (int k = 0; k < 2; k++)
		begin
			run(txs[k], cfgs[k], d);
			mask = (9'h1 << ((cfgs[k][2:0] == 3'h0) ? 4'h8 : {1'b0, cfgs[k][2:0]})) - 9'h1;
			check("rx_loop", d[7:0] & mask[7:0], txs[k] & mask[7:0]);
			check("ss_frozen", pins.ss, 1'b0);
		end
		check("pins_quiet", edges, e0);
		wr(`OFS_DIAG, 32'h0);
		@(posedge clk);
		check("ss_release", pins.ss, 1'b1);
		// second entry: other phase and polarity, select high at entry
		wr(`OFS_CFG, 32'h78);
		wr(`OFS_DIAG, 32'h1);
		@(posedge clk);
		e0 = edges;
		run(8'h3C, 8'h68, d);
		check("rx_phase1", d[7:0], 8'h3C);
		check("ss_frozen1", pins.ss, 1'b1);
		check("sclk_idle", pins.sclk, 1'b1);
		check("pins_quiet1", edges, e0);
		results();
	end
endmodule // serial_master_loopback_tb_top
